// [drive_io_pkg.sv]
// Constants shared by the drive I/O image packer and its buffer
package drive_io_pkg;
  localparam int          AUX_WORDS   = 10;
  localparam int          BUF_DEPTH   = 2;
  localparam int          BYTE_W      = 8;
  localparam int          WORD_W      = 16;
  localparam int          IDX_W       = 5;
  localparam int          STREAM_W    = 9;
  localparam int          LAST_BIT    = 8;
  localparam int          BASIC_BYTES = 24;
  localparam int          EXT_BYTES   = 4;
  localparam logic [4:0]  BASIC_LEN   = 5'h18;
  localparam logic [4:0]  EXT_LEN     = 5'h04;
  localparam int          CTRL_BYTE   = 0;
  localparam int          STATE_BYTE  = 1;
  localparam int          SPEED_BYTE  = 2;
  localparam int          AUX_BYTE    = 4;
  // Output image, byte 0
  localparam int          OUT_RUN_FWD   = 0;
  localparam int          OUT_RUN_REV   = 1;
  localparam int          OUT_FAULT_RST = 2;
  localparam int          OUT_NET_CTRL  = 5;
  localparam int          OUT_NET_REF   = 6;
  // Input image, byte 0
  localparam int          IN_FAULTED  = 0;
  localparam int          IN_WARNING  = 1;
  localparam int          IN_RUN_FWD  = 2;
  localparam int          IN_RUN_REV  = 3;
  localparam int          IN_READY    = 4;
  localparam int          IN_CTRL_NET = 5;
  localparam int          IN_REF_NET  = 6;
  localparam int          IN_AT_REF   = 7;
  typedef enum logic {TX_IDLE, TX_SEND} tx_state_type;
endpackage

// [byte_stream_if.sv]
// Valid/ready byte stream between the packer and its buffer
interface byte_stream_if #(parameter int WIDTH = drive_io_pkg::STREAM_W);
  logic [WIDTH-1:0] data;
  logic             valid;
  logic             ready;
  modport source (output data, output valid, input ready);
  modport sink   (input data, input valid, output ready);
endinterface

// [stream_buffer.sv]
// Shift-register buffer with registered head, valid and ready on both sides
module stream_buffer #(
  parameter int WIDTH = drive_io_pkg::STREAM_W,
  parameter int DEPTH = drive_io_pkg::BUF_DEPTH
) (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  byte_stream_if.sink    fill,
  byte_stream_if.source  drain
);
  logic [DEPTH-1:0] valid_reg;
  logic [WIDTH-1:0] data_reg [DEPTH];
  logic [DEPTH-1:0] shifted_valid;
  logic [WIDTH-1:0] shifted_data [DEPTH];
  wire              pop  = valid_reg[0] & drain.ready;
  wire              push = fill.valid & fill.ready;

  // Honest full: no bypass, so ready never depends on the drain side
  assign fill.ready  = ~valid_reg[DEPTH-1];
  assign drain.valid = valid_reg[0];
  assign drain.data  = data_reg[0];

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++) begin : g_entry
      wire below_full;
      wire load;
      if (i == DEPTH - 1) begin : g_top
        assign shifted_valid[i] = pop ? 1'b0 : valid_reg[i];
        assign shifted_data[i]  = data_reg[i];
      end else begin : g_mid
        assign shifted_valid[i] = pop ? valid_reg[i+1] : valid_reg[i];
        assign shifted_data[i]  = pop ? data_reg[i+1] : data_reg[i];
      end
      if (i == 0) begin : g_head
        assign below_full = 1'b1;
      end else begin : g_body
        assign below_full = shifted_valid[i-1];
      end
      assign load = push & ~shifted_valid[i] & below_full;
      always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
          valid_reg[i] <= 1'b0;
          data_reg[i]  <= '0;
        end else begin
          valid_reg[i] <= shifted_valid[i] | load;
          data_reg[i]  <= load ? fill.data : shifted_data[i];
        end
      end
    end
  endgenerate
endmodule

// [drive_io_assembly_packer.sv]
// Drive cyclic I/O image unpacker (output images) and packer (input images)
module drive_io_assembly_packer #(
  parameter int AUX_WORDS = drive_io_pkg::AUX_WORDS
) (
  input  wire logic                    sys_clk,
  input  wire logic                    rst_b,
  input  wire logic                    rx_ext_select,
  input  wire logic [7:0]              rx_data,
  input  wire logic                    rx_valid,
  input  wire logic                    rx_last,
  output logic                         rx_ready,
  output logic                         run_forward,
  output logic                         run_reverse,
  output logic                         fault_reset_request,
  output logic                         network_control_request,
  output logic                         setpoint_from_network_request,
  output logic [15:0]                  speed_setpoint,
  output logic [AUX_WORDS*16-1:0]      aux_out_words,
  output logic                         out_image_done,
  output logic                         out_image_error,
  input  wire logic                    tx_ext_select,
  input  wire logic                    tx_request,
  input  wire logic                    faulted,
  input  wire logic                    warning,
  input  wire logic                    running_forward,
  input  wire logic                    running_reverse,
  input  wire logic                    drive_ready,
  input  wire logic                    control_from_network,
  input  wire logic                    setpoint_from_network,
  input  wire logic                    at_setpoint,
  input  wire logic [7:0]              drive_state,
  input  wire logic [15:0]             speed_actual,
  input  wire logic [AUX_WORDS*16-1:0] aux_in_words,
  output logic                         tx_busy,
  output logic [7:0]                   tx_data,
  output logic                         tx_valid,
  output logic                         tx_last,
  input  wire logic                    tx_ready
);
  localparam int IMG_W = drive_io_pkg::BASIC_BYTES * drive_io_pkg::BYTE_W;
  localparam int B     = drive_io_pkg::BYTE_W;

  // Receive side
  logic                          rx_ready_reg;
  logic [drive_io_pkg::IDX_W-1:0] rx_idx_reg;
  logic                          rx_bad_reg;
  logic [IMG_W-1:0]              rx_image_reg;
  logic                          commit_reg;
  logic                          commit_ext_reg;
  logic                          run_forward_reg;
  logic                          run_reverse_reg;
  logic                          fault_reset_reg;
  logic                          net_ctrl_reg;
  logic                          net_ref_reg;
  logic [15:0]                   setpoint_reg;
  logic [AUX_WORDS*16-1:0]       aux_out_reg;
  logic                          done_reg;
  logic                          error_reg;

  wire                           rx_take  = rx_valid & rx_ready_reg;
  wire [drive_io_pkg::IDX_W-1:0] rx_len   = rx_ext_select ? drive_io_pkg::EXT_LEN : drive_io_pkg::BASIC_LEN;
  wire                           rx_over  = rx_idx_reg >= rx_len;
  wire                           rx_final = rx_idx_reg == rx_len - 5'h01;
  wire                           rx_good  = rx_take & rx_last & ~rx_bad_reg & rx_final;
  wire [7:0]                     rx_ctrl  = rx_image_reg[drive_io_pkg::CTRL_BYTE*B +: B];

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rx_ready_reg <= 1'b0;
      rx_idx_reg   <= '0;
      rx_bad_reg   <= 1'b0;
      rx_image_reg <= '0;
    end else begin
      // Ready from the first cycle after reset: the image store never stalls
      rx_ready_reg <= 1'b1;
      if (rx_take && !rx_over) begin
        rx_image_reg[rx_idx_reg*B +: B] <= rx_data;
      end
      if (rx_take) begin
        rx_idx_reg <= rx_last ? '0 : (rx_over ? rx_idx_reg : rx_idx_reg + 5'h01);
        rx_bad_reg <= rx_last ? 1'b0 : (rx_bad_reg | rx_over);
      end
    end
  end

  // Commit one cycle after the last byte, so a short or long image never reaches the outputs
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      commit_reg     <= 1'b0;
      commit_ext_reg <= 1'b0;
      done_reg       <= 1'b0;
      error_reg      <= 1'b0;
    end else begin
      commit_reg     <= rx_good;
      commit_ext_reg <= rx_ext_select;
      done_reg       <= commit_reg;
      error_reg      <= rx_take & rx_last & ~rx_good;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      run_forward_reg <= 1'b0;
      run_reverse_reg <= 1'b0;
      fault_reset_reg <= 1'b0;
      net_ctrl_reg    <= 1'b0;
      net_ref_reg     <= 1'b0;
      setpoint_reg    <= 16'h0000;
      aux_out_reg     <= '0;
    end else if (commit_reg) begin
      run_forward_reg <= rx_ctrl[drive_io_pkg::OUT_RUN_FWD];
      fault_reset_reg <= rx_ctrl[drive_io_pkg::OUT_FAULT_RST];
      setpoint_reg    <= rx_image_reg[drive_io_pkg::SPEED_BYTE*B +: 16];
      // Basic image has no reverse or network bits; byte 1 is ignored and bytes 4 to 23 load the auxiliary words
      run_reverse_reg <= commit_ext_reg & rx_ctrl[drive_io_pkg::OUT_RUN_REV];
      net_ctrl_reg    <= commit_ext_reg & rx_ctrl[drive_io_pkg::OUT_NET_CTRL];
      net_ref_reg     <= commit_ext_reg & rx_ctrl[drive_io_pkg::OUT_NET_REF];
      if (!commit_ext_reg) begin
        aux_out_reg <= rx_image_reg[drive_io_pkg::AUX_BYTE*B +: AUX_WORDS*16];
      end
    end
  end

  assign rx_ready                      = rx_ready_reg;
  assign run_forward                   = run_forward_reg;
  assign run_reverse                   = run_reverse_reg;
  assign fault_reset_request           = fault_reset_reg;
  assign network_control_request       = net_ctrl_reg;
  assign setpoint_from_network_request = net_ref_reg;
  assign speed_setpoint                = setpoint_reg;
  assign aux_out_words                 = aux_out_reg;
  assign out_image_done                = done_reg;
  assign out_image_error               = error_reg;

  // Transmit side
  drive_io_pkg::tx_state_type     tx_state_reg;
  logic [drive_io_pkg::IDX_W-1:0] tx_idx_reg;
  logic                           tx_ext_reg;
  logic [IMG_W-1:0]               tx_image_reg;
  logic [IMG_W-1:0]               tx_image_next;
  logic [7:0]                     status_byte;

  byte_stream_if #(.WIDTH(drive_io_pkg::STREAM_W)) fill_if ();
  byte_stream_if #(.WIDTH(drive_io_pkg::STREAM_W)) drain_if ();

  always_comb begin
    status_byte                            = 8'h00;
    status_byte[drive_io_pkg::IN_FAULTED]  = faulted;
    status_byte[drive_io_pkg::IN_RUN_FWD]  = running_forward;
    if (tx_ext_select) begin
      status_byte[drive_io_pkg::IN_WARNING]  = warning;
      status_byte[drive_io_pkg::IN_RUN_REV]  = running_reverse;
      status_byte[drive_io_pkg::IN_READY]    = drive_ready;
      status_byte[drive_io_pkg::IN_CTRL_NET] = control_from_network;
      status_byte[drive_io_pkg::IN_REF_NET]  = setpoint_from_network;
      status_byte[drive_io_pkg::IN_AT_REF]   = at_setpoint;
    end
  end

  always_comb begin
    tx_image_next                                        = '0;
    tx_image_next[drive_io_pkg::CTRL_BYTE*B +: B]        = status_byte;
    tx_image_next[drive_io_pkg::SPEED_BYTE*B +: 16]      = speed_actual;
    if (tx_ext_select) begin
      tx_image_next[drive_io_pkg::STATE_BYTE*B +: B]     = drive_state;
    end else begin
      tx_image_next[drive_io_pkg::AUX_BYTE*B +: AUX_WORDS*16] = aux_in_words;
    end
  end

  wire [drive_io_pkg::IDX_W-1:0] tx_len  = tx_ext_reg ? drive_io_pkg::EXT_LEN : drive_io_pkg::BASIC_LEN;
  wire                           tx_end  = tx_idx_reg == tx_len - 5'h01;
  wire                           tx_push = (tx_state_reg == drive_io_pkg::TX_SEND) & fill_if.ready;

  assign fill_if.valid = tx_state_reg == drive_io_pkg::TX_SEND;
  assign fill_if.data  = {tx_end, tx_image_reg[tx_idx_reg*B +: B]};

  // Snapshot at the request, so a frame never mixes two status samples
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      tx_state_reg <= drive_io_pkg::TX_IDLE;
      tx_idx_reg   <= '0;
      tx_ext_reg   <= 1'b0;
      tx_image_reg <= '0;
    end else begin
      case (tx_state_reg)
        drive_io_pkg::TX_IDLE: begin
          if (tx_request) begin
            tx_state_reg <= drive_io_pkg::TX_SEND;
            tx_idx_reg   <= '0;
            tx_ext_reg   <= tx_ext_select;
            tx_image_reg <= tx_image_next;
          end
        end
        drive_io_pkg::TX_SEND: begin
          if (tx_push) begin
            tx_idx_reg <= tx_idx_reg + 5'h01;
            if (tx_end) begin
              tx_state_reg <= drive_io_pkg::TX_IDLE;
            end
          end
        end
        default: begin
          tx_state_reg <= drive_io_pkg::TX_IDLE;
        end
      endcase
    end
  end

  stream_buffer #(
    .WIDTH (drive_io_pkg::STREAM_W),
    .DEPTH (drive_io_pkg::BUF_DEPTH)
  ) u_tx_buffer (
    .sys_clk (sys_clk),
    .rst_b   (rst_b),
    .fill    (fill_if),
    .drain   (drain_if)
  );

  assign drain_if.ready = tx_ready;
  assign tx_valid       = drain_if.valid;
  assign tx_data        = drain_if.data[B-1:0];
  assign tx_last        = drain_if.data[drive_io_pkg::LAST_BIT];

  // Busy only while the sequencer walks; buffered bytes may still be draining
  assign tx_busy = tx_state_reg == drive_io_pkg::TX_SEND;
endmodule

// [drive_io_assembly_packer_assertions.sv]
// Port-level assertions for the drive I/O image packer
module drive_io_assembly_packer_assertions #(
  parameter int AUX_WORDS = drive_io_pkg::AUX_WORDS
) (
  input wire logic                   sys_clk,
  input wire logic                   rst_b,
  input wire logic                   rx_ext_select,
  input wire logic [7:0]             rx_data,
  input wire logic                   rx_valid,
  input wire logic                   rx_ready,
  input wire logic                   rx_last,
  input wire logic                   run_forward,
  input wire logic                   run_reverse,
  input wire logic                   network_control_request,
  input wire logic                   setpoint_from_network_request,
  input wire logic [15:0]            speed_setpoint,
  input wire logic [AUX_WORDS*16-1:0] aux_out_words,
  input wire logic                   out_image_done,
  input wire logic                   out_image_error,
  input wire logic                   tx_ext_select,
  input wire logic                   tx_request,
  input wire logic                   faulted,
  input wire logic                   running_forward,
  input wire logic                   tx_busy,
  input wire logic [7:0]             tx_data,
  input wire logic                   tx_valid,
  input wire logic                   tx_ready
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence tx_start;
    tx_request && !tx_busy && !tx_valid;
  endsequence
  sequence busy_then_byte;
    tx_busy ##1 tx_valid;
  endsequence
  a_ready_after_reset: assert property (rst_b && $past(rst_b) && $past(rst_b, 2) |-> rx_ready)
    else $error("receive side not ready after reset");
  a_done_error_apart: assert property (!(out_image_done && out_image_error))
    else $error("done and error together");
  a_done_after_last: assert property (out_image_done |-> $past(rx_valid && rx_ready && rx_last, 2))
    else $error("done without a final byte two cycles before");
  a_error_after_last: assert property (out_image_error |-> $past(rx_valid && rx_ready && rx_last))
    else $error("error without a final byte one cycle before");
  a_basic_clears_ext: assert property (out_image_done && !$past(rx_ext_select, 2) |->
    !(run_reverse || network_control_request || setpoint_from_network_request))
    else $error("basic image left extended bits set");
  a_ext_speed_high: assert property (out_image_done && $past(rx_ext_select, 2) |->
    speed_setpoint[15:8] == $past(rx_data, 2))
    else $error("extended setpoint high byte wrong");
  a_aux_high_byte: assert property (out_image_done && !$past(rx_ext_select, 2) |->
    aux_out_words[AUX_WORDS*16-1 -: 8] == $past(rx_data, 2))
    else $error("last auxiliary word high byte wrong");
  a_outputs_hold: assert property (!out_image_done |->
    $stable(speed_setpoint) && $stable(aux_out_words) && $stable(run_forward))
    else $error("decoded outputs moved without done");
  a_tx_data_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("transmit byte changed while stalled");
  a_tx_start_order: assert property (tx_start |=> busy_then_byte)
    else $error("transmit start not followed by busy then byte");
  a_basic_status: assert property (!tx_ext_select && tx_request && !tx_busy && !tx_valid |->
    ##2 tx_data == {5'h00, $past(running_forward, 2), 1'b0, $past(faulted, 2)})
    else $error("basic status byte wrong");
endmodule

bind drive_io_assembly_packer drive_io_assembly_packer_assertions #(.AUX_WORDS(AUX_WORDS)) chk (
  .sys_clk                       (sys_clk),
  .rst_b                         (rst_b),
  .rx_ext_select                 (rx_ext_select),
  .rx_data                       (rx_data),
  .rx_valid                      (rx_valid),
  .rx_ready                      (rx_ready),
  .rx_last                       (rx_last),
  .run_forward                   (run_forward),
  .run_reverse                   (run_reverse),
  .network_control_request       (network_control_request),
  .setpoint_from_network_request (setpoint_from_network_request),
  .speed_setpoint                (speed_setpoint),
  .aux_out_words                 (aux_out_words),
  .out_image_done                (out_image_done),
  .out_image_error               (out_image_error),
  .tx_ext_select                 (tx_ext_select),
  .tx_request                    (tx_request),
  .faulted                       (faulted),
  .running_forward               (running_forward),
  .tx_busy                       (tx_busy),
  .tx_data                       (tx_data),
  .tx_valid                      (tx_valid),
  .tx_ready                      (tx_ready)
);

// [controller_model.sv]
// Controller-side model: sends output images, collects input images
module controller_model (
  input  wire logic       sys_clk,
  output logic            rx_ext_select,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_last,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [8:0] got [$];
  logic       stall;
  int         cyc;
  initial begin
    {rx_ext_select, rx_valid, rx_last, tx_ready, stall} = 5'h00;
    rx_data = 8'h00;
    cyc = 0;
  end
  // Spare bits go out as the caller gives them, to probe the receiver
  task automatic send(input logic ext, input logic [7:0] img [24], input int n);
    for (int i = 0; i < n; i++) begin
      rx_ext_select = ext;
      rx_data = img[i];
      rx_valid = 1'b1;
      rx_last = (i == n - 1);
      @(posedge sys_clk) #1;
    end
    rx_valid = 1'b0;
    rx_last = 1'b0;
    rx_data = ~rx_data;
  endtask
  // Stall opens the sink one cycle in three, so the buffer backs up
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) got.push_back({tx_last, tx_data});
    cyc <= cyc + 1;
    #1 tx_ready = !stall || (cyc % 3 == 0);
  end
endmodule

// [drive_io_assembly_packer_tb.sv]
// Self-checking bench for the drive I/O image packer
module drive_io_assembly_packer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int AW = drive_io_pkg::AUX_WORDS * 16;
  logic          sys_clk, rst_b, rx_sel, rx_valid, rx_last, rx_ready, tx_sel, tx_request;
  logic          done, err, tx_busy, tx_valid, tx_last, tx_ready;
  wire  [4:0]    cmd;
  logic [7:0]    rx_data, tx_data, st, dstate;
  logic [15:0]   speed, spd_act;
  logic [AW-1:0] aux_out, aux_in, aux_exp;
  logic [7:0]    img [24];
  int            err_total, check_count;
  drive_io_assembly_packer dut (.sys_clk, .rst_b, .rx_ext_select(rx_sel), .rx_data, .rx_valid, .rx_last,
    .rx_ready, .run_forward(cmd[0]), .run_reverse(cmd[1]), .fault_reset_request(cmd[2]),
    .network_control_request(cmd[3]), .setpoint_from_network_request(cmd[4]), .speed_setpoint(speed),
    .aux_out_words(aux_out), .out_image_done(done), .out_image_error(err), .tx_ext_select(tx_sel), .tx_request,
    .faulted(st[0]), .warning(st[1]), .running_forward(st[2]), .running_reverse(st[3]), .drive_ready(st[4]),
    .control_from_network(st[5]), .setpoint_from_network(st[6]), .at_setpoint(st[7]), .drive_state(dstate),
    .speed_actual(spd_act), .aux_in_words(aux_in), .tx_busy, .tx_data, .tx_valid, .tx_last, .tx_ready);
  controller_model ctl (.sys_clk, .rx_ext_select(rx_sel), .rx_data, .rx_valid, .rx_last, .tx_data, .tx_valid,
    .tx_last, .tx_ready);
  task automatic check(input string what, input logic [AW-1:0] exp, input logic [AW-1:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rx_image(input logic ext, input int n, input logic [7:0] b0, input logic [15:0] spd);
    int k;
    img[0] = b0;
    img[1] = 8'hFF;
    {img[3], img[2]} = spd;
    for (k = 0; k < 10; k++) {img[5+2*k], img[4+2*k]} = {8'hB0 + 8'(k), 8'h10 + 8'(k)};
    ctl.send(ext, img, n);
    for (k = 0; k < 8 && (n == (ext ? 4 : 24) ? done : err) !== 1'b1; k++) @(posedge sys_clk) #1;
    check("answer pulse", 1, k < 8);
    if (k == 8) tally_and_finish();
  endtask
  task automatic tx_frame(input logic ext, input logic [7:0] s);
    logic [7:0] e [24];
    int n, k;
    n = ext ? 4 : 24;
    st = s;
    tx_sel = ext;
    tx_request = 1'b1;
    e[0] = ext ? s : (s & 8'h05);
    e[1] = ext ? dstate : 8'h00;
    {e[3], e[2]} = spd_act;
    for (k = 0; k < 20; k++) e[4+k] = aux_in[8*k +: 8];
    @(posedge sys_clk) #1;
    tx_request = 1'b0;
    for (k = 0; k < 200 && ctl.got.size() < n; k++) @(posedge sys_clk) #1;
    check("tx frame in time", 1, k < 200);
    if (k == 200) tally_and_finish();
    for (k = 0; k < n; k++) check("tx byte", {k == n - 1, e[k]}, ctl.got[k]);
    ctl.got.delete();
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    {rst_b, tx_sel, tx_request, err_total, check_count} = 0;
    st = 8'h00;
    dstate = 8'h3C;
    spd_act = 16'hBEEF;
    for (int i = 0; i < AW / 8; i++) aux_in[8*i +: 8] = 8'h50 + 8'(3 * i);
    for (int i = 0; i < AW / 16; i++) aux_exp[16*i +: 16] = {8'hB0 + 8'(i), 8'h10 + 8'(i)};
    repeat (2) @(posedge sys_clk);
    #1 rst_b = 1'b1;
    repeat (2) @(posedge sys_clk) #1;
    rx_image(1, 4, 8'hBE, 16'h8001);
    check("ext cmd", 5'h0E, cmd);
    check("ext speed", 16'h8001, speed);
    check("aux idle", 0, aux_out);
    rx_image(1, 4, 8'h41, 16'h7FFE);
    check("ext cmd", 5'h11, cmd);
    rx_image(0, 24, 8'hFF, 16'h1234);
    check("basic cmd", 5'h05, cmd);
    check("basic speed", 16'h1234, speed);
    check("aux words", aux_exp, aux_out);
    rx_image(1, 3, 8'h02, 16'hFFFF);
    rx_image(0, 23, 8'h00, 16'h0000);
    check("cmd kept", 5'h05, cmd);
    check("speed kept", 16'h1234, speed);
    check("aux kept", aux_exp, aux_out);
    ctl.stall = 1'b1;
    tx_frame(0, 8'hFF);
    tx_frame(1, 8'hA5);
    ctl.stall = 1'b0;
    tx_frame(1, 8'h5A);
    tx_frame(0, 8'hFA);
    tally_and_finish();
  end
endmodule
